/* File: cps_divider.sv */
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: start is ignored while busy
// Notes:   a zero divisor yields an all-ones quotient
`timescale 1ns/1ps
module cps_divider
  import cps_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             start,
  input  wire logic [NUM_W-1:0] num,
  input  wire logic [DEN_W-1:0] den,
  output logic                  done,
  output logic      [NUM_W-1:0] quot
);
  typedef struct packed {
    logic             busy;
    logic             done;
    logic [6:0]       left;
    logic [DEN_W:0]   rem;
    logic [NUM_W-1:0] q;
    logic [DEN_W-1:0] d;
  } cps_div_st_t;

  cps_div_st_t    r;
  cps_div_st_t    n;
  logic [DEN_W:0] sh;

  always_comb
  begin
    n      = r;
    n.done = 1'b0;
    sh     = {r.rem[DEN_W-1:0], r.q[NUM_W-1]};
    if (!r.busy && start)
    begin
      n.busy = 1'b1;
      n.left = 7'(NUM_W);
      n.rem  = '0;
      n.q    = num;
      n.d    = den;
    end
    else if (r.busy)
    begin
      n.q = {r.q[NUM_W-2:0], 1'b0};
      if (sh >= {1'b0, r.d})
      begin
        n.rem  = sh - {1'b0, r.d};
        n.q[0] = 1'b1;
      end
      else
        n.rem = sh;
      n.left = r.left - 7'h01;
      if (r.left == 7'h01)
      begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= n;
  end

  assign done = r.done;
  assign quot = r.q;

endmodule : cps_divider

/* File: cps_fifo.sv */
// Purpose: result buffer with registered read data
// Assumes: DEPTH is a power of two
// Notes:   in_ready drops when full, so the writer must hold its word
`timescale 1ns/1ps
module cps_fifo
  import cps_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 32
)(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } cps_fifo_st_t;

  cps_fifo_st_t r;
  cps_fifo_st_t n;
  logic         push;
  logic         pop;

  always_comb
  begin
    n    = r;
    push = in_valid && (r.cnt != CW'(DEPTH));
    pop  = (!r.ov || out_ready) && (r.cnt != '0);
    if (push)
    begin
      n.mem[r.wp] = in_data;
      n.wp        = r.wp + 1'b1;
    end
    if (pop)
    begin
      n.od = r.mem[r.rp];
      n.ov = 1'b1;
      n.rp = r.rp + 1'b1;
    end
    else if (out_ready)
    begin
      n.ov = 1'b0;
    end
    n.cnt = r.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= n;
  end

  assign in_ready  = (r.cnt != CW'(DEPTH));
  assign out_valid = r.ov;
  assign out_data  = r.od;

endmodule : cps_fifo

/* File: cps_period_stats.sv */
// Purpose: per-period statistics of a sampled channel between cycle
//          events, with a built-in fixed interval event generator
// Assumes: interval and offset arrive as whole sample periods; samples
//          are marked by SAMPLE.valid, events by one-cycle pulses
// Notes:   results leave through a FIFO, one record per period closed while the sequencer is idle
//
// Summary of operation
// R01: interval generator repeats events at fixed spacing
// R02: first generated event at interval plus offset
// R03: interval and offset in whole sample periods
// R04: software keeps interval at 500 us or more
// R05: software keeps offset within plus/minus interval
// R06: zero offset puts first event one interval in
// R07: frequency result issued per cycle period
// R08: frequency corrected for cycles-per-event and half-cycle
// R09: largest sample of each period reported
// R10: smallest sample of each period reported
// R11: arithmetic mean of each period reported
// R12: fundamental phase difference of both inputs
// R13: phase in radians, zero to two pi, B ahead
// R14: phase yields quiet NaN below minimum frequency
// R15: fundamental RMS reported once per cycle
// R16: RMS yields quiet NaN below minimum frequency
// R17: peak-to-peak as maximum minus minimum
// R18: event closes period, latches, clears accumulators
`timescale 1ns/1ps
module cps_period_stats
  import cps_pkg::*;
#(
  parameter logic [31:0] SAMPLE_RATE_HZ = 32'd1000000,
  parameter int          FIFO_DEPTH     = 32
)(
  input  wire logic              CLOCK,
  input  wire logic              ARST_N,
  input  wire logic              ACQ_START,
  input  wire cps_sample_t       SAMPLE,
  input  wire logic              CYCLE_EVENT,
  input  wire logic              CYCLE_SEL,
  input  wire cps_cycle_cfg_t    CYCLE_CFG,
  input  wire cps_interval_cfg_t INTERVAL_CFG,
  input  wire logic [31:0]       MIN_FUND_FREQ,
  input  wire logic              RESULT_READY,
  output logic                   RESULT_VALID,
  output cps_result_t            RESULT,
  output logic                   CYCLE_MARK,
  output logic                   OVERRUN
);
  localparam int RES_W = $bits(cps_result_t);

  cps_main_st_t            r;
  cps_main_st_t            n;
  logic                    gen_fire;
  logic                    ev;
  logic signed [15:0]      sn;
  logic signed [15:0]      cs;
  logic signed [31:0]      pac;
  logic signed [31:0]      pas;
  logic signed [31:0]      pbc;
  logic signed [31:0]      pbs;
  logic        [6:0]       cyc2;
  logic        [ACC_W-1:0] abs_sum;
  logic        [65:0]      rms_prod;
  logic        [31:0]      ph_prod;
  logic        [15:0]      ang_diff;
  logic        [NUM_W-1:0] div_num;
  logic        [DEN_W-1:0] div_den;
  logic                    div_done;
  logic        [NUM_W-1:0] div_q;
  logic        [31:0]      q32;
  logic                    fifo_ready;

  // numerator factor: twice the input cycles spanned by one event
  assign cyc2 = CYCLE_CFG.half ? 7'h01 : {CYCLE_CFG.count, 1'b0}; // R08

  assign abs_sum  = r.s_sum[ACC_W-1] ? ACC_W'(-r.s_sum) : r.s_sum;
  assign rms_prod = 66'(r.xa) * 66'(RMS_GAIN_Q16);
  assign ang_diff = r.angb - r.anga; // R12 R13
  assign ph_prod  = 32'(ang_diff) * 32'(RAD_PER_TURN_Q13);
  assign q32      = div_q[31:0];

  // one divider serves the four quotients in turn
  always_comb
  begin
    div_num = '0;
    div_den = r.s_cnt;
    case (r.op)
      2'd0:
        div_num = NUM_W'({abs_sum, 8'h00}); // R11
      2'd1:
      begin
        div_num = NUM_W'({SAMPLE_RATE_HZ * 32'(cyc2), 8'h00}); // R07 R08
        div_den = {r.s_cnt[DEN_W-2:0], 1'b0};
      end
      2'd2:
        div_num = NUM_W'({cyc2, 31'h00000000});
      default:
        div_num = NUM_W'(rms_prod[65:22]); // R15
    endcase
  end

  always_comb
  begin
    n        = r;
    n.mark   = 1'b0;
    gen_fire = 1'b0;
    sn       = cps_sin(r.ph[31:26]);
    cs       = cps_sin(r.ph[31:26] + 6'd16);
    pac      = 32'(SAMPLE.a) * 32'(cs);
    pas      = 32'(SAMPLE.a) * 32'(sn);
    pbc      = 32'(SAMPLE.b) * 32'(cs);
    pbs      = 32'(SAMPLE.b) * 32'(sn);

    if (SAMPLE.valid && r.run)
    begin
      if (r.cnt == '0 || SAMPLE.a > r.max)
        n.max = SAMPLE.a; // R09
      if (r.cnt == '0 || SAMPLE.a < r.min)
        n.min = SAMPLE.a; // R10
      n.sum = r.sum + ACC_W'(SAMPLE.a); // R11
      n.cnt = r.cnt + 1'b1;
      // below the minimum frequency the fundamental is not tracked
      if (r.dft_en)
      begin
        n.ia = r.ia + ACC_W'(pac); // R12 R15
        n.qa = r.qa + ACC_W'(pas);
        n.ib = r.ib + ACC_W'(pbc);
        n.qb = r.qb + ACC_W'(pbs);
        n.ph = r.ph + r.inc;
      end
      if (r.gen_cnt <= 32'sd1)
      begin
        gen_fire  = 1'b1; // R01
        n.gen_cnt = $signed(INTERVAL_CFG.interval); // R01 R03
      end
      else
        n.gen_cnt = r.gen_cnt - 32'sd1;
    end

    ev = r.run && (CYCLE_SEL ? gen_fire : CYCLE_EVENT);

    if (ev)
    begin
      n.mark = 1'b1;
      if (r.fsm == ST_IDLE && n.cnt != '0)
      begin
        // the sample taken with the event still belongs to this period
        n.res.maximum = n.max; // R18
        n.res.minimum = n.min;
        n.res.span    = 17'(n.max) - 17'(n.min); // R17
        n.s_sum       = n.sum;
        n.s_cnt       = n.cnt;
        // phase vectors are (I, -Q); fold left half-plane first
        n.xa   = n.ia[ACC_W-1] ? -VEC_W'(n.ia) : VEC_W'(n.ia);
        n.ya   = n.ia[ACC_W-1] ? VEC_W'(n.qa) : -VEC_W'(n.qa);
        n.anga = n.ia[ACC_W-1] ? HALF_TURN : 16'h0000;
        n.xb   = n.ib[ACC_W-1] ? -VEC_W'(n.ib) : VEC_W'(n.ib);
        n.yb   = n.ib[ACC_W-1] ? VEC_W'(n.qb) : -VEC_W'(n.qb);
        n.angb = n.ib[ACC_W-1] ? HALF_TURN : 16'h0000;
        n.it   = 4'h0;
        n.fsm  = ST_CORD;
      end
      else if (r.fsm != ST_IDLE)
        n.ovr = 1'b1;
      n.cnt = '0; // R18
      n.sum = '0;
      n.ia  = '0;
      n.qa  = '0;
      n.ib  = '0;
      n.qb  = '0;
      n.ph  = '0;
    end

    case (r.fsm)
      ST_IDLE:
      begin
        // an event above may already have started the sequencer
      end
      ST_CORD:
      begin
        if (r.ya[VEC_W-1])
        begin
          n.xa   = r.xa - (r.ya >>> r.it);
          n.ya   = r.ya + (r.xa >>> r.it);
          n.anga = r.anga - ATAN_TURNS[r.it];
        end
        else
        begin
          n.xa   = r.xa + (r.ya >>> r.it);
          n.ya   = r.ya - (r.xa >>> r.it);
          n.anga = r.anga + ATAN_TURNS[r.it];
        end
        if (r.yb[VEC_W-1])
        begin
          n.xb   = r.xb - (r.yb >>> r.it);
          n.yb   = r.yb + (r.xb >>> r.it);
          n.angb = r.angb - ATAN_TURNS[r.it];
        end
        else
        begin
          n.xb   = r.xb + (r.yb >>> r.it);
          n.yb   = r.yb - (r.xb >>> r.it);
          n.angb = r.angb + ATAN_TURNS[r.it];
        end
        n.it = r.it + 4'h1;
        if (r.it == 4'(CORDIC_N - 1))
        begin
          n.op  = 2'd0;
          n.fsm = ST_DIV;
        end
      end
      ST_DIV:
        n.fsm = ST_WAIT;
      ST_WAIT:
      begin
        if (div_done)
        begin
          n.op  = r.op + 2'd1;
          n.fsm = ST_DIV;
          case (r.op)
            2'd0:
              n.res.average = r.s_sum[ACC_W-1] ? -q32 : q32; // R11
            2'd1:
            begin
              n.res.freq     = q32; // R07
              n.res.fund_nan = (q32 < MIN_FUND_FREQ); // R14 R16
              n.dft_en       = (q32 >= MIN_FUND_FREQ); // R14 R16
            end
            2'd2:
              n.inc = r.res.fund_nan ? 32'h00000000 : q32; // R12
            default:
            begin
              n.fsm = ST_PUSH;
              n.res.fund_rms = r.res.fund_nan ? QUIET_NOT_A_NUMBER
                                              : q32; // R15 R16
              n.res.fund_phase = r.res.fund_nan ? QUIET_NOT_A_NUMBER
                                  : {16'h0000, ph_prod[31:16]}; // R13 R14
            end
          endcase
        end
      end
      ST_PUSH:
        if (fifo_ready)
          n.fsm = ST_IDLE;
      default:
        n.fsm = ST_IDLE;
    endcase

    if (ACQ_START)
    begin
      n.run    = 1'b1;
      n.ovr    = ev && (r.fsm != ST_IDLE);
      n.cnt    = '0;
      n.sum    = '0;
      n.ia     = '0;
      n.qa     = '0;
      n.ib     = '0;
      n.qb     = '0;
      n.ph     = '0;
      n.inc    = '0;
      n.dft_en = 1'b0;
      n.fsm    = ST_IDLE;
      // offset port left at zero gives first event one interval in
      n.gen_cnt = $signed(INTERVAL_CFG.interval) +
                  ((INTERVAL_CFG.offset == $signed(OFFSET_ZERO)) ?
                   32'sd0 : INTERVAL_CFG.offset); // R02 R05 R06
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      r     <= '0;
      r.fsm <= ST_IDLE;
    end
    else
      r <= n;
  end

  cps_divider u_div (
    .clk    (CLOCK),
    .arst_n (ARST_N),
    .start  (r.fsm == ST_DIV),
    .num    (div_num),
    .den    (div_den),
    .done   (div_done),
    .quot   (div_q)
  );

  // the sequencer waits in ST_PUSH while the buffer is full
  cps_fifo #(
    .W     (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .arst_n    (ARST_N),
    .in_valid  (r.fsm == ST_PUSH),
    .in_ready  (fifo_ready),
    .in_data   (r.res),
    .out_valid (RESULT_VALID),
    .out_ready (RESULT_READY),
    .out_data  (RESULT)
  );

  assign CYCLE_MARK = r.mark;
  assign OVERRUN    = r.ovr;

endmodule : cps_period_stats

/* File: cps_period_stats_props.sv */
// Purpose: port checker of cps_period_stats
// Assumes: one clock domain, events spaced apart by the stimulus
// Notes:   run_r mirrors acquisition start as seen at the ports
`timescale 1ns/1ps
module cps_period_stats_props
  import cps_pkg::*;
(
  input wire logic              CLOCK,
  input wire logic              ARST_N,
  input wire logic              ACQ_START,
  input wire cps_sample_t       SAMPLE,
  input wire logic              CYCLE_EVENT,
  input wire logic              CYCLE_SEL,
  input wire cps_cycle_cfg_t    CYCLE_CFG,
  input wire cps_interval_cfg_t INTERVAL_CFG,
  input wire logic [31:0]       MIN_FUND_FREQ,
  input wire logic              RESULT_READY,
  input wire logic              RESULT_VALID,
  input wire cps_result_t       RESULT,
  input wire logic              CYCLE_MARK,
  input wire logic              OVERRUN
);
  logic run_r;
  always_ff @(posedge CLOCK or negedge ARST_N)
    if (!ARST_N) run_r <= 1'b0;
    else if (ACQ_START) run_r <= 1'b1;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  sequence s_evt; run_r && !CYCLE_SEL && CYCLE_EVENT; endsequence
  sequence s_mark; CYCLE_MARK ##1 !CYCLE_MARK; endsequence
  property p_mark; s_evt |=> s_mark; endproperty
  a_mark: assert property (p_mark) else $error("mark missing");
  property p_nomark;
    !CYCLE_SEL && !(run_r && CYCLE_EVENT) |=> !CYCLE_MARK;
  endproperty
  a_nomark: assert property (p_nomark) else $error("stray mark");
  property p_hold;
    RESULT_VALID && !RESULT_READY |=> RESULT_VALID && $stable(RESULT);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_span;
    RESULT_VALID |-> RESULT.span == 17'(RESULT.maximum - RESULT.minimum);
  endproperty
  a_span: assert property (p_span) else $error("span wrong");
  property p_order; RESULT_VALID |-> RESULT.maximum >= RESULT.minimum;
  endproperty
  a_order: assert property (p_order) else $error("max below min");
  property p_avg;
    RESULT_VALID |-> $signed(RESULT.average) <= 32'sd256 * RESULT.maximum
      && $signed(RESULT.average) >= 32'sd256 * RESULT.minimum;
  endproperty
  a_avg: assert property (p_avg) else $error("mean out of range");
  property p_nan;
    RESULT_VALID && RESULT.fund_nan |-> RESULT.fund_rms == QUIET_NOT_A_NUMBER
      && RESULT.fund_phase == QUIET_NOT_A_NUMBER;
  endproperty
  a_nan: assert property (p_nan) else $error("nan code wrong");
  property p_phase;
    RESULT_VALID && !RESULT.fund_nan |->
      RESULT.fund_phase <= {16'h0000, RAD_PER_TURN_Q13};
  endproperty
  a_phase: assert property (p_phase) else $error("phase range");
  property p_ovr;
    ACQ_START && !(CYCLE_SEL ? SAMPLE.valid : CYCLE_EVENT) |=> !OVERRUN;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun kept");
endmodule : cps_period_stats_props
bind cps_period_stats cps_period_stats_props i_props (.CLOCK, .ARST_N,
  .ACQ_START, .SAMPLE, .CYCLE_EVENT, .CYCLE_SEL, .CYCLE_CFG,
  .INTERVAL_CFG, .MIN_FUND_FREQ, .RESULT_READY, .RESULT_VALID, .RESULT,
  .CYCLE_MARK, .OVERRUN);

/* File: cps_pkg.sv */
// Purpose: shared constants, tables and carrier types of the
//          cycle period statistics block
// Assumes: samples are signed 16-bit, times are whole sample periods
// Notes:   fixed point results carry FRAC_W fraction bits, fund_phase carries 13
package cps_pkg;

  localparam int SMP_W    = 16;
  localparam int ACC_W    = 48;
  localparam int VEC_W    = 50;
  localparam int CNT_W    = 32;
  localparam int FRAC_W   = 8;
  localparam int CORDIC_N = 16;
  localparam int NUM_W    = 64;
  localparam int DEN_W    = 32;

  // quiet not-a-number code placed in fundamental results
  localparam logic [31:0] QUIET_NOT_A_NUMBER = 32'h7FC00000;
  // sqrt(2) / cordic gain, Q16
  localparam logic [15:0] RMS_GAIN_Q16       = 16'hDBD9;
  // two pi, Q13, for turns-to-radians
  localparam logic [15:0] RAD_PER_TURN_Q13   = 16'hC910;
  localparam logic [15:0] HALF_TURN          = 16'h8000;
  localparam logic [31:0] OFFSET_ZERO        = 32'h00000000;

  // atan(2^-i) in 1/65536 turns
  localparam logic [0:CORDIC_N-1][15:0] ATAN_TURNS = {
    16'h2000, 16'h12E4, 16'h09FB, 16'h0511, 16'h028B, 16'h0146,
    16'h00A3, 16'h0051, 16'h0029, 16'h0014, 16'h000A, 16'h0005,
    16'h0003, 16'h0001, 16'h0001, 16'h0000};

  // quarter sine, 17 points, Q14
  localparam logic [0:16][15:0] SIN_Q14 = {
    16'h0000, 16'h0646, 16'h0C7C, 16'h1294, 16'h187E, 16'h1E2B,
    16'h238E, 16'h289A, 16'h2D41, 16'h3179, 16'h3537, 16'h3871,
    16'h3B21, 16'h3D3F, 16'h3EC5, 16'h3FB1, 16'h4000};

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CORD = 5'b00010,
    ST_DIV  = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_PUSH = 5'b10000
  } cps_fsm_t;

  typedef struct packed {
    logic                    valid;
    logic signed [SMP_W-1:0] a;
    logic signed [SMP_W-1:0] b;
  } cps_sample_t;

  typedef struct packed {
    logic       half;
    logic [5:0] count;
  } cps_cycle_cfg_t;

  typedef struct packed {
    logic        [CNT_W-1:0] interval;
    logic signed [CNT_W-1:0] offset;
  } cps_interval_cfg_t;

  typedef struct packed {
    logic signed [SMP_W-1:0] maximum;
    logic signed [SMP_W-1:0] minimum;
    logic        [SMP_W:0]   span;
    logic signed [31:0]      average;
    logic        [31:0]      freq;
    logic        [31:0]      fund_rms;
    logic        [31:0]      fund_phase;
    logic                    fund_nan;
  } cps_result_t;

  typedef struct packed {
    logic                    run;
    logic                    ovr;
    logic                    mark;
    logic signed [CNT_W-1:0] gen_cnt;
    logic signed [SMP_W-1:0] max;
    logic signed [SMP_W-1:0] min;
    logic signed [ACC_W-1:0] sum;
    logic        [CNT_W-1:0] cnt;
    logic signed [ACC_W-1:0] ia;
    logic signed [ACC_W-1:0] qa;
    logic signed [ACC_W-1:0] ib;
    logic signed [ACC_W-1:0] qb;
    logic        [31:0]      ph;
    logic        [31:0]      inc;
    logic                    dft_en;
    logic signed [ACC_W-1:0] s_sum;
    logic        [CNT_W-1:0] s_cnt;
    logic signed [VEC_W-1:0] xa;
    logic signed [VEC_W-1:0] ya;
    logic signed [VEC_W-1:0] xb;
    logic signed [VEC_W-1:0] yb;
    logic        [15:0]      anga;
    logic        [15:0]      angb;
    logic        [3:0]       it;
    cps_fsm_t                fsm;
    logic        [1:0]       op;
    cps_result_t             res;
  } cps_main_st_t;

  // sine of a 6-bit phase (64 steps per turn), Q14
  function automatic logic signed [15:0] cps_sin(input logic [5:0] p);
    logic [15:0] mag;
    mag = p[4] ? SIN_Q14[5'd16 - {1'b0, p[3:0]}] : SIN_Q14[{1'b0, p[3:0]}];
    return p[5] ? -$signed(mag) : $signed(mag);
  endfunction : cps_sin

endpackage : cps_pkg

/* File: cps_src_model.sv */
// Purpose: upstream sample path and cycle detector model
// Assumes: one sample per clock while enabled
// Notes:   idle data toggles so stale values never look valid
`timescale 1ns/1ps
module cps_src_model
  import cps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        en,
  input  wire logic [15:0] gap,
  output cps_sample_t      smp,
  output logic             evt
);
  int          cnt;
  int          lim;
  integer      seed = 32'h0300FC4C;
  logic [31:0] rnd;
  always @(negedge clk or negedge arst_n)
    if (!arst_n)
    begin
      smp <= '0;
      evt <= 1'b0;
      cnt = 0;
      lim = 0;
    end
    else if (en)
    begin
      rnd = $random(seed);
      // jitter only on long periods, short ones are overrun tests
      if (lim == 0) lim = gap + (gap > 16'h0064 ? rnd[23:16] : 0);
      cnt = cnt + 1;
      smp.valid <= 1'b1;
      smp.a <= rnd[31:29] == 3'h0 ? 16'h8000 :
               rnd[31:29] == 3'h1 ? 16'h7FFF : rnd[31:16];
      smp.b <= rnd[15:0];
      evt <= cnt == lim;
      if (cnt == lim) lim = 0;
      if (lim == 0) cnt = 0;
    end
    else
    begin
      smp.valid <= 1'b0;
      smp.a <= ~smp.a;
      smp.b <= ~smp.b;
      evt <= 1'b0;
      cnt = 0;
      lim = 0;
    end
endmodule : cps_src_model

/* File: test_cps_period_stats.sv */
// Purpose: self-checking bench of cps_period_stats
// Assumes: 50 MHz clock, sample rate parameter 1 MHz
// Notes:   expected records are rebuilt from the driven samples
`timescale 1ns/1ps
module test_cps_period_stats
  import cps_pkg::*;
;
  localparam logic [31:0] FS = 32'h000F4240;
  logic CLOCK = 1'b0, ARST_N, ACQ_START = 1'b0, CYCLE_SEL = 1'b0;
  logic RESULT_READY = 1'b0, RESULT_VALID, CYCLE_MARK, OVERRUN, CYCLE_EVENT;
  cps_cycle_cfg_t    CYCLE_CFG = '0;
  cps_interval_cfg_t INTERVAL_CFG = '0;
  logic [31:0]       MIN_FUND_FREQ = '0;
  cps_sample_t       SAMPLE;
  cps_result_t       RESULT, e, e2, exp_q[$];
  logic              en = 1'b0, stall = 1'b0, run = 1'b0, sel, chk = 1'b0;
  logic              mark_due;
  logic [15:0]       gap = 16'h0140;
  logic [31:0]       rnd;
  integer            seed = 32'h0300FC4C;
  int miscompares = 0, num_checks = 0, idx, n, nev, first, intv, k;
  longint            sum;
  always #10 CLOCK = ~CLOCK;
  cps_period_stats #(.SAMPLE_RATE_HZ(FS), .FIFO_DEPTH(32)) i_dut (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .ACQ_START(ACQ_START),
    .SAMPLE(SAMPLE), .CYCLE_EVENT(CYCLE_EVENT), .CYCLE_SEL(CYCLE_SEL),
    .CYCLE_CFG(CYCLE_CFG), .INTERVAL_CFG(INTERVAL_CFG),
    .MIN_FUND_FREQ(MIN_FUND_FREQ), .RESULT_READY(RESULT_READY),
    .RESULT_VALID(RESULT_VALID), .RESULT(RESULT),
    .CYCLE_MARK(CYCLE_MARK), .OVERRUN(OVERRUN));
  cps_src_model i_src (.clk(CLOCK), .arst_n(ARST_N), .en(en), .gap(gap),
    .smp(SAMPLE), .evt(CYCLE_EVENT));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  function automatic logic [31:0] f_freq(input int cnt);
    longint c;
    c = CYCLE_CFG.half ? 1 : 2 * CYCLE_CFG.count;
    return 32'((longint'(FS) * 256 * c) / (2 * cnt));
  endfunction : f_freq
  task automatic pulse_start;
    @(negedge CLOCK);
    ACQ_START = 1'b1;
    @(negedge CLOCK);
    ACQ_START = 1'b0;
  endtask : pulse_start
  task automatic bounded(input int what);
    k = 0;
    while ((what == 0 ? nev < 4 : what == 1 ? exp_q.size() > 0 : !OVERRUN)
           && k < 5000)
    begin
      @(negedge CLOCK);
      k++;
    end
    if (k >= 5000)
    begin
      miscompares++;
      final_report;
    end
  endtask : bounded
  always @(negedge CLOCK)
  begin
    rnd = $random(seed);
    RESULT_READY = !stall & rnd[4];
  end
  always @(posedge CLOCK)
    if (ACQ_START)
    begin
      {run, idx, n, sum, nev, mark_due, sel} = {1'b1, 32'h0, 32'h0,
        64'h0, 32'h0, 1'b0, CYCLE_SEL};
      intv = INTERVAL_CFG.interval;
      first = INTERVAL_CFG.interval + INTERVAL_CFG.offset;
    end
    else if (run)
    begin
      if (chk) check(CYCLE_MARK, mark_due);
      mark_due = 1'b0;
      if (SAMPLE.valid)
      begin
        idx++;
        if (n == 0 || SAMPLE.a > e.maximum) e.maximum = SAMPLE.a;
        if (n == 0 || SAMPLE.a < e.minimum) e.minimum = SAMPLE.a;
        sum += SAMPLE.a;
        n++;
        if (sel ? idx == first || (idx > first && (idx - first) % intv == 0)
                : CYCLE_EVENT)
        begin
          e.span = 17'(e.maximum - e.minimum);
          e.average = 32'((sum * 256) / n);
          e.freq = f_freq(n);
          e.fund_nan = e.freq < MIN_FUND_FREQ;
          if (chk) exp_q.push_back(e);
          {nev, n, sum, mark_due} = {nev + 1, 32'h0, 64'h0, 1'b1};
        end
      end
    end
  always @(posedge CLOCK)
    if (RESULT_VALID && RESULT_READY && chk)
    begin
      check(exp_q.size() > 0, 1'b1);
      e2 = exp_q.pop_front();
      check(RESULT.maximum, e2.maximum);
      check(RESULT.minimum, e2.minimum);
      check(RESULT.span, e2.span);
      check(RESULT.average, e2.average);
      if (!sel) check(RESULT.freq, e2.freq);
      check(RESULT.fund_nan, e2.fund_nan);
      if (e2.fund_nan) check(RESULT.fund_rms, QUIET_NOT_A_NUMBER);
      if (e2.fund_nan) check(RESULT.fund_phase, QUIET_NOT_A_NUMBER);
    end
  initial
  begin
    ARST_N = 1'b0;
    repeat (3) @(negedge CLOCK);
    ARST_N = 1'b1;
    chk = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      CYCLE_SEL = i > 1;
      CYCLE_CFG = i == 0 ? 7'h40 : 7'h32;
      // interval of 500 samples or more, offset within one interval
      INTERVAL_CFG = i == 2 ? {32'h0000_0258, 32'hFFFF_FF38}
                            : {32'h0000_01F4, OFFSET_ZERO};
      MIN_FUND_FREQ = i == 1 ? 32'hFFFF_FFFF : 32'h0000_0000;
      stall = i == 1;
      pulse_start;
      en <= 1'b1;
      bounded(0);
      en <= 1'b0;
      stall = 1'b0;
      bounded(1);
      repeat (400) @(negedge CLOCK);
      check(exp_q.size(), 0);
    end
    chk = 1'b0;
    CYCLE_SEL = 1'b0;
    gap = 16'h0014;
    pulse_start;
    en <= 1'b1;
    bounded(2);
    check(OVERRUN, 1'b1);
    en <= 1'b0;
    @(negedge CLOCK);
    pulse_start;
    check(OVERRUN, 1'b0);
    final_report;
  end
endmodule : test_cps_period_stats
